// ---- core/dbg_write_pkg.sv ----
// constants, field layout and state type shared by the debug write paths
// assumes one clock domain and a plain register port on the debugger side
package dbg_write_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int SIZE_W = 3;
    localparam int REGNO_W = 16;
    localparam int RADDR_W = 4;
    localparam int SB_ENTRY_W = ADDR_W + DATA_W + SIZE_W;
    localparam int SB_DEPTH = 16;
    // register indices on the register port
    localparam logic [RADDR_W-1:0] OFF_ARG0 = 4'h0;
    localparam logic [RADDR_W-1:0] OFF_ARG1 = 4'h1;
    localparam logic [RADDR_W-1:0] OFF_COMMAND = 4'h2;
    localparam logic [RADDR_W-1:0] OFF_AUTOEXEC = 4'h3;
    localparam logic [RADDR_W-1:0] OFF_SLOT0 = 4'h4;
    localparam logic [RADDR_W-1:0] OFF_SLOT1 = 4'h5;
    localparam logic [RADDR_W-1:0] OFF_ABS_STATUS = 4'h6;
    localparam logic [RADDR_W-1:0] OFF_BUS_CTRL = 4'h7;
    localparam logic [RADDR_W-1:0] OFF_BUS_ADDR = 4'h8;
    localparam logic [RADDR_W-1:0] OFF_BUS_DATA = 4'h9;
    // command word fields
    localparam int CMD_TYPE_HI = 31;
    localparam int CMD_TYPE_LO = 24;
    localparam int CMD_SIZE_HI = 22;
    localparam int CMD_SIZE_LO = 20;
    localparam int CMD_POSTINC = 19;
    localparam int CMD_POSTEXEC = 18;
    localparam int CMD_TRANSFER = 17;
    localparam int CMD_WRITE = 16;
    localparam int CMD_REGNO_HI = 15;
    localparam logic [7:0] CMDTYPE_REG = 8'h00;
    localparam logic [7:0] CMDTYPE_MEM = 8'h02;
    localparam logic [SIZE_W-1:0] SIZE_WORD = 3'h2;
    // bus control fields
    localparam int BC_ACCESS_HI = 2;
    localparam int BC_AUTOINC = 3;
    localparam int BC_ERR = 4;
    localparam int BC_BUSY = 5;
    localparam logic [SIZE_W-1:0] BUS_ACCESS_RST = 3'h2;
    // abstract status fields
    localparam int AS_ERR_HI = 2;
    localparam int AS_BUSY = 3;
    localparam int AE_ARG0 = 0;
    localparam logic [2:0] CMDERR_NONE = 3'h0;
    localparam logic [2:0] CMDERR_BUSY = 3'h1;
    localparam logic [2:0] CMDERR_NOTSUP = 3'h2;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ONE_BYTE = 32'h0000_0001;

    typedef enum logic [2:0] {
        ST_IDLE, ST_REG, ST_EXEC_GO, ST_EXEC_WAIT, ST_MEM_GO, ST_MEM_WAIT
    } cmd_state_type;

    function automatic logic [ADDR_W-1:0] sizeBytes(input logic [SIZE_W-1:0] s);
        return ONE_BYTE << s;
    endfunction
endpackage

// ---- core/debug_memory_write_paths.sv ----
// debugger-side memory write paths: system bus master and abstract commands
// assumes inputs synchronous to mclk and a hart that answers its requests
//
// How it works
// - bus addresses pass through untranslated, physical
// - bus transfer size taken from access code
// - bus data write starts a bus write unless the queue is full
// - autoincrement advances bus address by size
// - hart executes program slots for memory writes
// - register transfer copies word0 into hart register
// - postexec runs program after register transfer
// - autoexec re-issues last command on word0 access
// - memory command stores word0 at word1 address
// - postincrement advances word1 by access size
// - memory command performed through hart's memory port
module debug_memory_write_paths
    import dbg_write_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [RADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // system bus write master
    output logic sbValid,
    output logic [ADDR_W-1:0] sbAddr,
    output logic [DATA_W-1:0] sbData,
    output logic [SIZE_W-1:0] sbSize,
    input wire logic sbReady,
    // hart register transfer
    output logic hartRegWe,
    output logic [REGNO_W-1:0] hartRegNum,
    output logic [DATA_W-1:0] hartRegData,
    // hart program execution
    output logic hartExecReq,
    input wire logic hartExecDone,
    input wire logic progIndex,
    output logic [DATA_W-1:0] progWord,
    // hart memory port
    output logic hartMemReq,
    output logic [ADDR_W-1:0] hartMemAddr,
    output logic [DATA_W-1:0] hartMemData,
    output logic [SIZE_W-1:0] hartMemSize,
    input wire logic hartMemDone
);
    cmd_state_type state_r;
    cmd_state_type state_nxt;
    logic [DATA_W-1:0] arg0_r;
    logic [DATA_W-1:0] arg1_r;
    logic [DATA_W-1:0] command_r;
    logic autoExec_r;
    logic [DATA_W-1:0] slot0_r;
    logic [DATA_W-1:0] slot1_r;
    logic [2:0] cmdErr_r;
    logic [2:0] cmdErr_nxt;
    logic [SIZE_W-1:0] busAccess_r;
    logic busAutoInc_r;
    logic busErr_r;
    logic [ADDR_W-1:0] busAddr_r;
    logic [DATA_W-1:0] regRdata_r;
    logic sbValid_r;
    logic [ADDR_W-1:0] sbAddr_r;
    logic [DATA_W-1:0] sbData_r;
    logic [SIZE_W-1:0] sbSize_r;
    logic hartRegWe_r;
    logic [REGNO_W-1:0] hartRegNum_r;
    logic [DATA_W-1:0] hartRegData_r;
    logic hartExecReq_r;
    logic [DATA_W-1:0] progWord_r;
    logic hartMemReq_r;
    logic [ADDR_W-1:0] hartMemAddr_r;
    logic [DATA_W-1:0] hartMemData_r;
    logic [SIZE_W-1:0] hartMemSize_r;

    // register port decode
    wire wrArg0 = regWrite && (regAddr == OFF_ARG0);
    wire wrArg1 = regWrite && (regAddr == OFF_ARG1);
    wire wrCommand = regWrite && (regAddr == OFF_COMMAND);
    wire wrAutoExec = regWrite && (regAddr == OFF_AUTOEXEC);
    wire wrSlot0 = regWrite && (regAddr == OFF_SLOT0);
    wire wrSlot1 = regWrite && (regAddr == OFF_SLOT1);
    wire wrAbsStatus = regWrite && (regAddr == OFF_ABS_STATUS);
    wire wrBusCtrl = regWrite && (regAddr == OFF_BUS_CTRL);
    wire wrBusAddr = regWrite && (regAddr == OFF_BUS_ADDR);
    wire wrBusData = regWrite && (regAddr == OFF_BUS_DATA);
    wire rdArg0 = regRead && (regAddr == OFF_ARG0);
    wire rdArg1 = regRead && (regAddr == OFF_ARG1);

    // abstract command launch
    wire busy = state_r != ST_IDLE;
    wire errClear = cmdErr_r == CMDERR_NONE;
    wire arg0Touch = wrArg0 || rdArg0;
    wire cmdFire = wrCommand && !busy && errClear;
    wire autoFire = arg0Touch && autoExec_r && !busy && errClear;
    wire launch = cmdFire || autoFire;
    wire [DATA_W-1:0] launchCmd = cmdFire ? regWdata : command_r;
    wire [7:0] lType = launchCmd[CMD_TYPE_HI:CMD_TYPE_LO];
    wire [SIZE_W-1:0] lSize = launchCmd[CMD_SIZE_HI:CMD_SIZE_LO];
    wire lTransfer = launchCmd[CMD_TRANSFER];
    wire lWrite = launchCmd[CMD_WRITE];
    wire lPostExec = launchCmd[CMD_POSTEXEC];
    // only register writes of word size, register commands without transfer, and memory writes up to a word
    wire regOk = (lType == CMDTYPE_REG) && (!lTransfer || (lWrite && lSize == SIZE_WORD));
    wire memOk = (lType == CMDTYPE_MEM) && lWrite && (lSize <= SIZE_WORD);
    wire badCmd = launch && !regOk && !memOk;
    // touching the argument words, or writing the command or slots, mid-command is refused
    wire busyTouch = busy && (wrCommand || arg0Touch || wrArg1 || rdArg1 || wrSlot0 || wrSlot1);

    // fields of the latched command used while running
    wire [SIZE_W-1:0] cSize = command_r[CMD_SIZE_HI:CMD_SIZE_LO];
    wire cPostInc = command_r[CMD_POSTINC];
    wire cPostExec = command_r[CMD_POSTEXEC];
    wire memFinish = (state_r == ST_MEM_WAIT) && hartMemDone;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (launch && regOk) begin
                    if (lTransfer) begin
                        state_nxt = ST_REG;
                    end else if (lPostExec) begin
                        state_nxt = ST_EXEC_GO;
                    end
                end else if (launch && memOk) begin
                    state_nxt = ST_MEM_GO;
                end
            end
            ST_REG: state_nxt = cPostExec ? ST_EXEC_GO : ST_IDLE;
            ST_EXEC_GO: state_nxt = ST_EXEC_WAIT;
            ST_EXEC_WAIT: begin
                // program ends with ebreak, hart reports done
                if (hartExecDone) state_nxt = ST_IDLE;
            end
            ST_MEM_GO: state_nxt = ST_MEM_WAIT;
            ST_MEM_WAIT: begin
                if (hartMemDone) state_nxt = ST_IDLE;
            end
        endcase
    end

    // error flag: a new error wins over a write-one clear
    always_comb begin
        cmdErr_nxt = cmdErr_r;
        if (wrAbsStatus) cmdErr_nxt = cmdErr_r & ~regWdata[AS_ERR_HI:0];
        if (busyTouch && errClear) cmdErr_nxt = CMDERR_BUSY;
        else if (badCmd) cmdErr_nxt = CMDERR_NOTSUP;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cmdErr_r <= CMDERR_NONE;
            command_r <= WORD_ZERO;
            autoExec_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmdErr_r <= cmdErr_nxt;
            if (cmdFire) command_r <= regWdata;
            if (wrAutoExec) autoExec_r <= regWdata[AE_ARG0];
        end
    end

    // argument words and program slots
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            arg0_r <= WORD_ZERO;
            arg1_r <= WORD_ZERO;
            slot0_r <= WORD_ZERO;
            slot1_r <= WORD_ZERO;
        end else begin
            if (wrArg0 && !busy) arg0_r <= regWdata;
            if (wrArg1 && !busy) begin
                arg1_r <= regWdata;
            end else if (memFinish && cPostInc) begin
                arg1_r <= arg1_r + sizeBytes(cSize);
            end
            if (wrSlot0 && !busy) slot0_r <= regWdata;
            if (wrSlot1 && !busy) slot1_r <= regWdata;
        end
    end

    // hart-facing requests, one-cycle pulses
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hartRegWe_r <= 1'b0;
            hartRegNum_r <= '0;
            hartRegData_r <= WORD_ZERO;
            hartExecReq_r <= 1'b0;
        end else begin
            hartRegWe_r <= state_r == ST_REG;
            hartExecReq_r <= state_r == ST_EXEC_GO;
            if (state_r == ST_REG) begin
                hartRegNum_r <= command_r[CMD_REGNO_HI:0];
                hartRegData_r <= arg0_r;
            end
        end
    end

    // memory command goes through the hart's own view of memory
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hartMemReq_r <= 1'b0;
            hartMemAddr_r <= WORD_ZERO;
            hartMemData_r <= WORD_ZERO;
            hartMemSize_r <= '0;
        end else begin
            hartMemReq_r <= state_r == ST_MEM_GO;
            if (state_r == ST_MEM_GO) begin
                hartMemAddr_r <= arg1_r;
                hartMemData_r <= arg0_r;
                hartMemSize_r <= cSize;
            end
        end
    end

    // program slot fetch for the hart
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            progWord_r <= WORD_ZERO;
        end else begin
            progWord_r <= progIndex ? slot1_r : slot0_r;
        end
    end

    // system bus path: writes queue in the FIFO, so a slow bus
    // does not lose back-to-back data writes until its 16 entries are full
    stream_if #(.W(SB_ENTRY_W)) fillS();
    stream_if #(.W(SB_ENTRY_W)) drainS();

    word_fifo #(.WIDTH(SB_ENTRY_W), .DEPTH(SB_DEPTH)) busQueue (
        .mclk(mclk),
        .resetn(resetn),
        .fillSide(fillS),
        .drainSide(drainS)
    );

    // address goes out exactly as written, no translation
    assign fillS.valid = wrBusData;
    assign fillS.data = {busAddr_r, regWdata, busAccess_r};
    wire busPush = wrBusData && fillS.ready;
    wire busOverflow = wrBusData && !fillS.ready;
    wire outFree = !sbValid_r || sbReady;
    assign drainS.ready = outFree;
    wire takeOut = drainS.valid && outFree;
    wire busBusy = drainS.valid || sbValid_r;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busAccess_r <= BUS_ACCESS_RST;
            busAutoInc_r <= 1'b0;
            busErr_r <= 1'b0;
            busAddr_r <= WORD_ZERO;
        end else begin
            if (wrBusCtrl) begin
                busAccess_r <= regWdata[BC_ACCESS_HI:0];
                busAutoInc_r <= regWdata[BC_AUTOINC];
            end
            // overflow sets, write-one clears, set wins
            if (busOverflow) begin
                busErr_r <= 1'b1;
            end else if (wrBusCtrl && regWdata[BC_ERR]) begin
                busErr_r <= 1'b0;
            end
            if (wrBusAddr) begin
                busAddr_r <= regWdata;
            end else if (busPush && busAutoInc_r) begin
                busAddr_r <= busAddr_r + sizeBytes(busAccess_r);
            end
        end
    end

    // output stage keeps bus signals straight from flops
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sbValid_r <= 1'b0;
            sbAddr_r <= WORD_ZERO;
            sbData_r <= WORD_ZERO;
            sbSize_r <= '0;
        end else begin
            if (takeOut) begin
                sbValid_r <= 1'b1;
                sbAddr_r <= drainS.data[SB_ENTRY_W-1 -: ADDR_W];
                sbData_r <= drainS.data[SIZE_W +: DATA_W];
                sbSize_r <= drainS.data[SIZE_W-1:0];
            end else if (sbReady) begin
                sbValid_r <= 1'b0;
            end
        end
    end

    // read-back selection
    wire [DATA_W-1:0] absStatusWord = {{(DATA_W-4){1'b0}}, busy, cmdErr_r};
    wire [DATA_W-1:0] busCtrlWord = {{(DATA_W-6){1'b0}}, busBusy, busErr_r, busAutoInc_r, busAccess_r};
    wire [DATA_W-1:0] autoWord = {{(DATA_W-1){1'b0}}, autoExec_r};
    wire [DATA_W-1:0] rdMux =
        (regAddr == OFF_ARG0) ? arg0_r :
        (regAddr == OFF_ARG1) ? arg1_r :
        (regAddr == OFF_COMMAND) ? command_r :
        (regAddr == OFF_AUTOEXEC) ? autoWord :
        (regAddr == OFF_SLOT0) ? slot0_r :
        (regAddr == OFF_SLOT1) ? slot1_r :
        (regAddr == OFF_ABS_STATUS) ? absStatusWord :
        (regAddr == OFF_BUS_CTRL) ? busCtrlWord :
        (regAddr == OFF_BUS_ADDR) ? busAddr_r :
        WORD_ZERO;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regRdata_r <= WORD_ZERO;
        end else begin
            regRdata_r <= regRead ? rdMux : WORD_ZERO;
        end
    end

    assign regRdata = regRdata_r;
    assign sbValid = sbValid_r;
    assign sbAddr = sbAddr_r;
    assign sbData = sbData_r;
    assign sbSize = sbSize_r;
    assign hartRegWe = hartRegWe_r;
    assign hartRegNum = hartRegNum_r;
    assign hartRegData = hartRegData_r;
    assign hartExecReq = hartExecReq_r;
    assign progWord = progWord_r;
    assign hartMemReq = hartMemReq_r;
    assign hartMemAddr = hartMemAddr_r;
    assign hartMemData = hartMemData_r;
    assign hartMemSize = hartMemSize_r;
endmodule // debug_memory_write_paths

// ---- core/stream_if.sv ----
// valid/ready stream carrier between the system bus write path and its write FIFO
// assumes both ends share one clock
interface stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source(output valid, output data, input ready);
    modport sink(input valid, input data, output ready);
endinterface

// ---- core/word_fifo.sv ----
// synchronous FIFO with valid/ready on both sides
// assumes one clock; output data is read straight from the array
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // streams
    stream_if.sink fillSide,
    stream_if.source drainSide
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wrPtr_r;
    logic [PW:0] rdPtr_r;
    wire full = (wrPtr_r[PW] != rdPtr_r[PW]) && (wrPtr_r[PW-1:0] == rdPtr_r[PW-1:0]);
    wire empty = wrPtr_r == rdPtr_r;
    wire push = fillSide.valid && !full;
    wire pop = drainSide.ready && !empty;

    assign fillSide.ready = !full;
    assign drainSide.valid = !empty;
    assign drainSide.data = mem[rdPtr_r[PW-1:0]];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_r[PW-1:0]] <= fillSide.data;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (push) wrPtr_r <= wrPtr_r + 1'b1;
            if (pop) rdPtr_r <= rdPtr_r + 1'b1;
        end
    end
endmodule // word_fifo

// ---- test/debug_memory_write_paths_properties.sv ----
// port-level checker for the write paths
// assumes the bench keeps bus and memory access size at word
module debug_memory_write_paths_properties
    import dbg_write_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [RADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regRdata,
    // system bus
    input wire logic sbValid,
    input wire logic [ADDR_W-1:0] sbAddr,
    input wire logic [DATA_W-1:0] sbData,
    input wire logic [SIZE_W-1:0] sbSize,
    input wire logic sbReady,
    // hart
    input wire logic hartRegWe,
    input wire logic hartExecReq,
    input wire logic hartMemReq,
    input wire logic [ADDR_W-1:0] hartMemAddr,
    input wire logic [DATA_W-1:0] hartMemData,
    input wire logic [SIZE_W-1:0] hartMemSize
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // command write or autoexec access of word0
    wire launchHit = (regWrite || regRead) && (regAddr == OFF_COMMAND || regAddr == OFF_ARG0);
    sequence bus_stall_s;
        sbValid && !sbReady;
    endsequence
    sequence reg_then_exec_s;
        hartRegWe ##1 hartExecReq;
    endsequence
    bus_hold_a: assert property (bus_stall_s |=> sbValid && $stable(sbAddr) && $stable(sbData))
        else $error("bus request changed while stalled");
    bus_size_a: assert property (sbValid |-> sbSize == SIZE_WORD)
        else $error("bus size not word");
    read_idle_a: assert property (!$past(regRead) |-> regRdata == WORD_ZERO)
        else $error("read data outside read slot");
    reg_cause_a: assert property (hartRegWe |-> $past(launchHit, 2))
        else $error("reg transfer without command");
    reg_pulse_a: assert property (hartRegWe |=> !hartRegWe)
        else $error("reg transfer over one cycle");
    exec_after_a: assert property (hartExecReq |-> $past(hartRegWe))
        else $error("program run not after reg transfer");
    exec_gap_a: assert property (reg_then_exec_s |=> !hartExecReq [*3])
        else $error("program run repeated too soon");
    mem_cause_a: assert property (hartMemReq |-> $past(launchHit, 2))
        else $error("memory write without command");
    mem_hold_a: assert property (hartMemReq |=> !hartMemReq && $stable(hartMemAddr) && $stable(hartMemData))
        else $error("memory request not held");
    mem_size_a: assert property (hartMemReq |-> hartMemSize == SIZE_WORD)
        else $error("memory size not word");
endmodule // debug_memory_write_paths_properties

bind debug_memory_write_paths debug_memory_write_paths_properties props_i (.*);

// ---- test/debug_memory_write_paths_tb.sv ----
// self-checking bench for the debug memory write paths
// assumes the model answers every request within a few cycles
module debug_memory_write_paths_tb;
    import dbg_write_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [RADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] e;
    } row_type;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [RADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic slow = 1'b0;
    logic hold = 1'b0;
    logic [DATA_W-1:0] regRdata, sbData, hartRegData, progWord, hartMemData, v;
    logic [ADDR_W-1:0] sbAddr, hartMemAddr;
    logic [SIZE_W-1:0] sbSize, hartMemSize;
    logic [REGNO_W-1:0] hartRegNum;
    logic sbValid, sbReady, hartRegWe, hartExecReq, hartExecDone, progIndex, hartMemReq, hartMemDone;
    logic [63:0] busLog[$], regLog[$], memLog[$];
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    row_type rows[8] = '{
        '{OFF_ARG0, 32'hA5A5_0F0F, 32'hA5A5_0F0F}, '{OFF_ARG1, 32'h8000_1000, 32'h8000_1000},
        '{OFF_SLOT0, 32'h0094_2023, 32'h0094_2023}, '{OFF_SLOT1, 32'h0010_0073, 32'h0010_0073},
        '{OFF_AUTOEXEC, 32'h0000_0000, 32'h0000_0000}, '{OFF_BUS_ADDR, 32'h1234_5678, 32'h1234_5678},
        '{OFF_BUS_CTRL, 32'h0000_000A, 32'h0000_000A}, '{4'hC, 32'hFFFF_FFFF, 32'h0000_0000}};

    debug_memory_write_paths debug_memory_write_paths_i (.*);
    hart_bus_model hart_bus_model_i (.*);

    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (sbValid && sbReady) busLog.push_back({sbAddr, sbData});
        if (hartRegWe) regLog.push_back({16'h0000, hartRegNum, hartRegData});
        if (hartMemReq) memLog.push_back({hartMemAddr, hartMemData});
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // one cycle per call; the strobes stay as set until the next call drives them
    task automatic drive(input logic w, input logic r, input logic [RADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        regWrite <= w;
        regRead <= r;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [RADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        drive(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [RADDR_W-1:0] a, output logic [DATA_W-1:0] q);
        drive(1'b0, 1'b1, a, WORD_ZERO);
        drive(1'b0, 1'b0, a, WORD_ZERO);
        q = regRdata;
    endtask
    task automatic settle(input logic [RADDR_W-1:0] a, input int pos);
        logic [DATA_W-1:0] q;
        for (int i = 0; i < 200; i++) begin
            rd(a, q);
            if (q[pos] === 1'b0) break;
        end
        check(q[pos], 1'b0);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        rd(OFF_BUS_CTRL, v);
        check(v, 32'h0000_0002);
        rd(OFF_ABS_STATUS, v);
        check(v, WORD_ZERO);
        $display("reset values done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            check(v, rows[i].e);
        end
        $display("register rows done");
        // autoincrement block, then two plain writes
        slow <= 1'b1;
        busLog.delete();
        wr(OFF_BUS_ADDR, 32'h8000_0000);
        for (int i = 0; i < 4; i++) wr(OFF_BUS_DATA, 32'hC0DE_0000 + DATA_W'(i));
        wr(OFF_BUS_CTRL, 32'h0000_0002);
        wr(OFF_BUS_DATA, 32'hC0DE_0004);
        wr(OFF_BUS_DATA, 32'hC0DE_0005);
        settle(OFF_BUS_CTRL, BC_BUSY);
        check(busLog.size(), 6);
        for (int i = 0; i < 6; i++)
            check(busLog[i], {32'h8000_0000 + ADDR_W'(4 * (i > 4 ? 4 : i)), 32'hC0DE_0000 + DATA_W'(i)});
        $display("bus writes done");
        // stall the bus until the queue refuses words
        hold <= 1'b1;
        busLog.delete();
        for (int i = 0; i < 20; i++) wr(OFF_BUS_DATA, 32'hF000_0000 + DATA_W'(i));
        rd(OFF_BUS_CTRL, v);
        check(v[BC_ERR], 1'b1);
        hold <= 1'b0;
        settle(OFF_BUS_CTRL, BC_BUSY);
        check(busLog.size() >= 16 && busLog.size() <= 18, 1'b1);
        foreach (busLog[i]) check(busLog[i][31:0], 32'hF000_0000 + DATA_W'(i));
        wr(OFF_BUS_CTRL, 32'h0000_0012);
        rd(OFF_BUS_CTRL, v);
        check(v, 32'h0000_0002);
        $display("bus queue full and drain done");
        // slot write: s0 takes address, s1 value and runs slots
        regLog.delete();
        wr(OFF_ARG0, 32'h8000_2000);
        wr(OFF_COMMAND, 32'h0023_1008);
        settle(OFF_ABS_STATUS, AS_BUSY);
        wr(OFF_ARG0, 32'h1111_0000);
        wr(OFF_COMMAND, 32'h0027_1009);
        settle(OFF_ABS_STATUS, AS_BUSY);
        wr(OFF_AUTOEXEC, 32'h0000_0001);
        wr(OFF_ARG0, 32'h1111_0001);
        settle(OFF_ABS_STATUS, AS_BUSY);
        wr(OFF_AUTOEXEC, 32'h0000_0000);
        wr(OFF_ARG0, 32'h1111_0002);
        settle(OFF_ABS_STATUS, AS_BUSY);
        check(regLog.size(), 3);
        check(regLog[0], 64'h0000_1008_8000_2000);
        check(regLog[1], 64'h0000_1009_1111_0000);
        check(regLog[2], 64'h0000_1009_1111_0001);
        check(hart_bus_model_i.execCnt, 2);
        check(hart_bus_model_i.fetched[0], 32'h0094_2023);
        check(hart_bus_model_i.fetched[1], 32'h0010_0073);
        $display("program slot writes done");
        // abstract memory block write with post-increment
        memLog.delete();
        wr(OFF_ARG1, 32'h8000_3000);
        wr(OFF_ARG0, 32'hBEEF_0000);
        wr(OFF_COMMAND, 32'h0229_0000);
        settle(OFF_ABS_STATUS, AS_BUSY);
        wr(OFF_AUTOEXEC, 32'h0000_0001);
        for (int i = 1; i < 3; i++) begin
            wr(OFF_ARG0, 32'hBEEF_0000 + DATA_W'(i));
            settle(OFF_ABS_STATUS, AS_BUSY);
        end
        wr(OFF_AUTOEXEC, 32'h0000_0000);
        rd(OFF_ARG1, v);
        check(v, 32'h8000_300C);
        check(memLog.size(), 3);
        foreach (memLog[i]) check(memLog[i], {32'h8000_3000 + ADDR_W'(4 * i), 32'hBEEF_0000 + DATA_W'(i)});
        $display("abstract memory writes done");
        // refused memory read, then word0 write while busy
        wr(OFF_COMMAND, 32'h0220_0000);
        rd(OFF_ABS_STATUS, v);
        check(v, 32'h0000_0002);
        wr(OFF_ABS_STATUS, 32'h0000_0007);
        wr(OFF_COMMAND, 32'h0027_1009);
        wr(OFF_ARG0, 32'hDEAD_0000);
        settle(OFF_ABS_STATUS, AS_BUSY);
        rd(OFF_ABS_STATUS, v);
        check(v, 32'h0000_0001);
        rd(OFF_ARG0, v);
        check(v, 32'hBEEF_0002);
        check(memLog.size(), 3);
        $display("refusals done");
        results();
    end
endmodule // debug_memory_write_paths_tb

// ---- test/hart_bus_model.sv ----
// stand-in for the hart and the system bus slave
// slow stretches answers, hold stalls the bus
module hart_bus_model
    import dbg_write_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // bench controls
    input wire logic slow,
    input wire logic hold,
    // system bus
    output logic sbReady,
    // hart
    input wire logic hartExecReq,
    output logic hartExecDone,
    output logic progIndex,
    input wire logic [DATA_W-1:0] progWord,
    input wire logic hartMemReq,
    output logic hartMemDone
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] fetched [2];
    int execCnt;
    int execStep;
    int memStep;
    logic tick;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tick <= 1'b0;
            sbReady <= 1'b0;
            hartExecDone <= 1'b0;
            hartMemDone <= 1'b0;
            progIndex <= 1'b0;
            execCnt <= 0;
            execStep <= 0;
            memStep <= 0;
        end else begin
            tick <= !tick;
            sbReady <= !hold && (!slow || tick);
            hartExecDone <= 1'b0;
            hartMemDone <= 1'b0;
            if (hartExecReq) begin
                execStep <= 1;
                progIndex <= 1'b0;
            end else if (execStep != 0) begin
                execStep <= execStep + 1;
                progIndex <= 1'b1;
                if (execStep == 2) fetched[0] <= progWord;
                if (execStep == 3) fetched[1] <= progWord;
                // last slot returns to debug
                if (execStep == (slow ? 8 : 3)) begin
                    hartExecDone <= 1'b1;
                    execCnt <= execCnt + 1;
                    execStep <= 0;
                end
            end
            if (hartMemReq) memStep <= 1;
            else if (memStep != 0) memStep <= memStep + 1;
            if (memStep == (slow ? 4 : 1)) begin
                hartMemDone <= 1'b1;
                memStep <= 0;
            end
        end
    end
endmodule // hart_bus_model
